// ==== logic/fpe_pkg.sv ====
// constants of the flash program/erase control block
package fpe_pkg;
    localparam logic [15:0] ARR_LO = 16'h7800;
    localparam logic [15:0] USER_HI = 16'h7FEE;
    localparam logic [15:0] TRIM_ADDR = 16'h7FEF;
    localparam logic [15:0] PROT_ADDR = 16'hFFF0;
    localparam logic [15:0] VEC_LO = 16'hFFF2;
    localparam logic [15:0] VEC_HI = 16'hFFFF;
    localparam logic [15:0] CTL_ADDR = 16'hFE08;
    localparam int IDX_W = 11;
    localparam int ARR_BYTES = 2048;
    localparam int ROW_BYTES = 8;
    localparam int ROW_LAST = 253;
    localparam logic [10:0] PROT_IDX = 11'h7F0;
    localparam int B_FDIV = 6;
    localparam int B_BLK = 4;
    localparam int B_HV = 3;
    localparam int B_MRG = 2;
    localparam int B_ERS = 1;
    localparam int B_PGM = 0;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] ERASED = 8'h00;
    localparam int MARGIN_STRETCH = 8;
    localparam logic [10:0] PSTART0 = 11'h000;
    localparam logic [10:0] PSTART1 = 11'h080;
    localparam logic [10:0] PSTART2 = 11'h100;
    localparam logic [10:0] PSTART3 = 11'h200;
    localparam logic [10:0] SPAN_FULL = 11'h7FF;
    localparam logic [10:0] SPAN_HALF = 11'h3FF;
    localparam logic [10:0] SPAN_OCT = 11'h03F;
    localparam logic [10:0] SPAN_ROW = 11'h007;
endpackage : fpe_pkg

// ==== logic/fpe_ctrl_top.sv ====
// flash program/erase control: control register, array, protection and margin read
`timescale 1ns/100ps
module fpe_ctrl_top #(
    parameter int STRETCH = fpe_pkg::MARGIN_STRETCH
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic slow_clk_i,
    input wire logic secure_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic hv_on_o,
    output logic pump_on_o,
    output logic pump_tick_o
);
    initial
    begin
        if (STRETCH < 1 || STRETCH > 15)
            $error("STRETCH must lie in 1..15");
        if ((fpe_pkg::ROW_LAST + 1) * fpe_pkg::ROW_BYTES != 2032)
            $error("row layout does not match user space");
    end

    // array bytes; contents survive reset like real flash cells, a fresh part starts erased
    logic [7:0] mem [0:fpe_pkg::ARR_BYTES-1] = '{default: fpe_pkg::ERASED};

    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic fdiv;
    logic [1:0] blk;
    logic high_voltage_enable;
    logic margin;
    logic erase;
    logic program_select;
    logic addr_seen;
    logic prot_seen;
    logic [10:0] lat_idx;
    logic [7:0] lat_data;
    logic [3:0] prot_lat;
    logic [3:0] stretch_cnt;
    logic [7:0] pend_data;
    logic div_ph;
    logic slow;
    logic secure;
    logic ctl_wr;
    logic arr_wr;
    logic arr_rd;
    logic rd_ok;
    logic sel;
    logic blocked;
    logic hv_ok;
    logic hv_set;
    logic [10:0] blk_end;
    logic [10:0] pstart;
    logic [7:0] arr_val;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= fpe_pkg::ARR_LO && a <= fpe_pkg::TRIM_ADDR)
            || a == fpe_pkg::PROT_ADDR
            || (a >= fpe_pkg::VEC_LO && a <= fpe_pkg::VEC_HI);
    endfunction : in_array

    function automatic logic [10:0] span_mask(input logic [1:0] size);
        case (size)
            2'h0: span_mask = fpe_pkg::SPAN_FULL;
            2'h1: span_mask = fpe_pkg::SPAN_HALF;
            2'h2: span_mask = fpe_pkg::SPAN_OCT;
            default: span_mask = fpe_pkg::SPAN_ROW;
        endcase
    endfunction : span_mask

    // level pins from other domains pass two flops first
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end
        else
        begin
            pin_meta <= {secure_i, slow_clk_i};
            pin_sync <= pin_meta;
        end
    end

    assign slow = pin_sync[0];
    assign secure = pin_sync[1];
    assign ctl_wr = wr_i && addr_i == fpe_pkg::CTL_ADDR;
    assign arr_wr = wr_i && in_array(addr_i);
    assign rd_ok = rd_i && stretch_cnt == 4'h0;
    assign arr_rd = rd_ok && in_array(addr_i);
    assign sel = program_select || erase;
    // erase ends at the top of the cared block, program at its own byte
    assign blk_end = erase ? (lat_idx | span_mask(blk)) : lat_idx;
    always_comb
    begin
        if (prot_lat[0])
            pstart = fpe_pkg::PSTART0;
        else if (prot_lat[1])
            pstart = fpe_pkg::PSTART1;
        else if (prot_lat[2])
            pstart = fpe_pkg::PSTART2;
        else
            pstart = fpe_pkg::PSTART3;
    end
    // protected ranges all run to the top, so comparing the end suffices
    assign blocked = prot_lat != 4'h0 && blk_end >= pstart;
    assign hv_ok = sel && addr_seen && prot_seen && !slow && !blocked;
    assign hv_set = ctl_wr && wdata_i[fpe_pkg::B_HV] && !high_voltage_enable && hv_ok;
    // security keeps array contents hidden
    assign arr_val = secure ? fpe_pkg::ERASED : mem[addr_i[10:0]];

    // control register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            {fdiv, blk, high_voltage_enable, margin, erase, program_select} <= fpe_pkg::CTL_RST[6:0];
        end
        else
        begin
            if (ctl_wr)
            begin
                fdiv <= wdata_i[fpe_pkg::B_FDIV];
                blk <= wdata_i[fpe_pkg::B_BLK +: 2];
                // a write asking for both selects leaves both select bits unchanged unless a protected target refuses it, which clears both; its other fields still apply
                // the write that raises high voltage keeps the selected operation type
                if (!high_voltage_enable && !hv_set
                    && !(wdata_i[fpe_pkg::B_ERS] && wdata_i[fpe_pkg::B_PGM]))
                begin
                    erase <= wdata_i[fpe_pkg::B_ERS];
                    program_select <= wdata_i[fpe_pkg::B_PGM];
                end
                if (!wdata_i[fpe_pkg::B_HV])
                    high_voltage_enable <= 1'b0;
                else if (hv_set)
                    high_voltage_enable <= 1'b1;
                else if (!high_voltage_enable && sel && addr_seen && prot_seen && blocked)
                begin
                    erase <= 1'b0;
                    program_select <= 1'b0;
                end
                margin <= wdata_i[fpe_pkg::B_MRG] && !high_voltage_enable && !hv_set;
            end
            if (slow)
            begin
                high_voltage_enable <= 1'b0;
                margin <= 1'b0;
            end
        end
    end

    // set-up sequence: target latch and protect byte latch
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            addr_seen <= 1'b0;
            prot_seen <= 1'b0;
            lat_idx <= 11'h000;
            lat_data <= 8'h00;
            prot_lat <= 4'h0;
        end
        else if (!sel)
        begin
            addr_seen <= 1'b0;
            prot_seen <= 1'b0;
        end
        else
        begin
            // trim byte is not a target for ordinary writes
            if (arr_wr && !high_voltage_enable && addr_i != fpe_pkg::TRIM_ADDR)
            begin
                addr_seen <= 1'b1;
                lat_idx <= addr_i[10:0];
                lat_data <= wdata_i;
            end
            if (rd_ok && addr_i == fpe_pkg::PROT_ADDR)
            begin
                prot_seen <= 1'b1;
                prot_lat <= mem[fpe_pkg::PROT_IDX][3:0];
            end
        end
    end

    // array update when high voltage comes on
    always_ff @(posedge clk_i)
    begin
        if (hv_set && program_select)
            mem[lat_idx] <= mem[lat_idx] | lat_data;
        if (hv_set && erase)
        begin
            for (int i = 0; i < fpe_pkg::ARR_BYTES; i++)
            begin
                if ((11'(i) & ~span_mask(blk)) == (lat_idx & ~span_mask(blk)))
                    mem[i] <= fpe_pkg::ERASED;
            end
        end
    end

    // bus read path; margin-mode array reads are stretched
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            stretch_cnt <= 4'h0;
            pend_data <= 8'h00;
        end
        else
        begin
            rvalid_o <= 1'b0;
            if (stretch_cnt != 4'h0)
            begin
                stretch_cnt <= stretch_cnt - 4'h1;
                if (stretch_cnt == 4'h1)
                begin
                    rvalid_o <= 1'b1;
                    rdata_o <= pend_data;
                end
            end
            else if (arr_rd && margin)
            begin
                stretch_cnt <= 4'(STRETCH);
                pend_data <= arr_val;
            end
            else if (rd_ok)
            begin
                rvalid_o <= 1'b1;
                if (in_array(addr_i))
                    rdata_o <= arr_val;
                else if (addr_i == fpe_pkg::CTL_ADDR)
                    rdata_o <= {1'b0, fdiv, blk, high_voltage_enable, margin, erase, program_select};
                else
                    rdata_o <= 8'h00;
            end
        end
    end

    // pump clock enable, derived from the bus clock only
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            div_ph <= 1'b0;
            pump_tick_o <= 1'b0;
        end
        else
        begin
            div_ph <= !div_ph;
            pump_tick_o <= high_voltage_enable && (!fdiv || div_ph);
        end
    end

    assign hv_on_o = high_voltage_enable;
    assign pump_on_o = high_voltage_enable;

    a_sel_interlock: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !(program_select && erase))
        else $error("program and erase selected together");

    a_hv_needs_sel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !$past(high_voltage_enable) && high_voltage_enable |-> $past(sel && addr_seen && prot_seen && ctl_wr))
        else $error("high voltage set without proper set-up");

    a_margin_hv_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        high_voltage_enable |-> !margin)
        else $error("margin set while high voltage on");

    a_slow_block_ops: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        slow |=> !high_voltage_enable && !margin)
        else $error("operation active on slow bus clock");

    a_sel_hold_hv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $past(high_voltage_enable) && high_voltage_enable |-> $stable(program_select) && $stable(erase))
        else $error("select changed under high voltage");

    a_pump_div_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        high_voltage_enable && !fdiv |=> pump_tick_o)
        else $error("undivided pump clock missed a cycle");

    a_pump_div_two: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        pump_tick_o && fdiv && $past(fdiv) |=> !pump_tick_o)
        else $error("halved pump clock ran too fast");

    a_margin_stretch: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        arr_rd && margin |=> !rvalid_o [*8] ##1 rvalid_o)
        else $error("margin read not stretched by eight cycles");

    a_plain_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rd_ok && !(arr_rd && margin) |=> rvalid_o)
        else $error("plain read not answered next cycle");

    a_erase_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        hv_set && erase |=> mem[lat_idx] == fpe_pkg::ERASED)
        else $error("erased target byte not zero");

    a_prog_bits: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        hv_set && program_select |=> (mem[lat_idx] & lat_data) == lat_data)
        else $error("programmed bits not set");

    a_protect_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ctl_wr && wdata_i[fpe_pkg::B_HV] && !high_voltage_enable && sel && addr_seen && prot_seen
        && blocked |=> !high_voltage_enable && !program_select && !erase)
        else $error("protected target not refused");
endmodule : fpe_ctrl_top

// ==== testbench/fpe_cpu_model.sv ====
// processor-side bus master model for the flash control block
`timescale 1ns/100ps
module fpe_cpu_model (
    input wire logic clk_i,
    input wire logic rvalid_i,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // the bench erases a row before a third program; every program sets the divider
    // and verifies each program by margin read
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // released lines must not keep the last value
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : wr_byte
    task automatic rd_byte(input logic [15:0] a, output int lat);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        lat = 0;
        // the answer is a one-cycle pulse, so it is looked at on the edge that ends its cycle
        do
        begin
            @(posedge clk_i);
            lat++;
        end
        while (rvalid_i !== 1'b1 && lat < 40);
    endtask : rd_byte
endmodule : fpe_cpu_model

// ==== testbench/flash_program_erase_control_test.sv ====
// self-checking bench for the flash program/erase control block
`timescale 1ns/100ps
module flash_program_erase_control_test;
    logic clk_i, arst_n_i, wr_i, rd_i, slow_clk_i, secure_i;
    logic [15:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic rvalid_o, hv_on_o, pump_on_o, pump_tick_o;
    logic [15:0] exp_q[$];
    logic [15:0] e, pa[2];
    logic [7:0] pd[2];
    int n_mismatch = 0;
    int n_tests = 0;
    int lat, nlat, cyc, seed;
    localparam logic [15:0] CTL = fpe_pkg::CTL_ADDR;
    localparam logic [15:0] PROT = fpe_pkg::PROT_ADDR;

    fpe_ctrl_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .slow_clk_i(slow_clk_i),
        .secure_i(secure_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .hv_on_o(hv_on_o),
        .pump_on_o(pump_on_o), .pump_tick_o(pump_tick_o));
    fpe_cpu_model u_cpu (.clk_i(clk_i), .rvalid_i(rvalid_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_cpu.wr_byte(a, d);
    endtask : wr
    // mask 00 means the answer is only counted, not judged
    task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
        exp_q.push_back({m, x});
        u_cpu.rd_byte(a, lat);
    endtask : rd
    task automatic hv_op(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] d,
        input logic [7:0] m, input logic [7:0] p);
        wr(CTL, sel);
        wr(a, d);
        rd(PROT, m, p);
        wr(CTL, sel | 8'h08);
        @(posedge clk_i);
        #1;
    endtask : hv_op
    task automatic ticks(input int n_exp);
        int n;
        n = 0;
        repeat (8)
        begin
            @(posedge clk_i);
            #1;
            if (pump_tick_o === 1'b1)
                n++;
        end
        chk("pump ticks", 8'(n), 8'(n_exp));
    endtask : ticks
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        hv_op(8'h41, a, d, 8'hFF, 8'h00);
        ticks(4);
        wr(CTL, 8'h41);
        wr(CTL, 8'h45);
        wr(CTL, 8'h44);
        rd(a, 8'hFF, d);
        if (a < 16'h8000)
            chk("margin stretch", 8'(lat - nlat), 8'(fpe_pkg::MARGIN_STRETCH));
        wr(CTL, 8'h00);
    endtask : prog

    always @(posedge clk_i)
    begin
        if (rvalid_o === 1'b1)
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFF5A;
            chk("read data", rdata_o & e[15:8], e[7:0]);
        end
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial
    begin
        arst_n_i = 1'b0;
        slow_clk_i = 1'b0;
        secure_i = 1'b0;
        seed = 58;
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(CTL, 8'hFF, fpe_pkg::CTL_RST);
        nlat = lat;
        $display("test reset done");
        wr(CTL, 8'h71);
        rd(CTL, 8'hFF, 8'h71);
        wr(CTL, 8'h43);
        rd(CTL, 8'hFF, 8'h41);
        wr(CTL, 8'h08);
        rd(CTL, 8'hFF, 8'h00);
        wr(CTL, 8'h01);
        wr(CTL, 8'h09);
        rd(CTL, 8'hFF, 8'h01);
        wr(CTL, 8'h00);
        $display("test control fields done");
        hv_op(8'h02, 16'h7800, 8'($random(seed)), 8'h00, 8'h00);
        chk("hv on", {6'h00, hv_on_o, pump_on_o}, 8'h03);
        ticks(8);
        wr(CTL, 8'h0E);
        rd(CTL, 8'hFF, 8'h0A);
        wr(CTL, 8'h09);
        rd(CTL, 8'hFF, 8'h0A);
        wr(CTL, 8'h02);
        #1;
        chk("hv off", {6'h00, hv_on_o, pump_on_o}, 8'h00);
        wr(CTL, 8'h00);
        rd(16'h7800, 8'hFF, fpe_pkg::ERASED);
        rd(PROT, 8'hFF, 8'h00);
        $display("test full erase done");
        for (int i = 0; i < 2; i++)
        begin
            pa[i] = 16'h7808 + 16'(i * 8) + 16'($random(seed) & 7);
            pd[i] = 8'($random(seed)) | 8'h01;
            prog(pa[i], pd[i]);
            rd(pa[i] ^ 16'h0001, 8'hFF, 8'h00);
        end
        $display("test program done");
        hv_op(8'h32, {pa[0][15:3], 3'h7}, 8'h00, 8'hFF, 8'h00);
        wr(CTL, 8'h32);
        wr(CTL, 8'h00);
        rd(pa[0], 8'hFF, 8'h00);
        rd(pa[1], 8'hFF, pd[1]);
        $display("test row erase done");
        slow_clk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        hv_op(8'h02, 16'h7800, 8'h00, 8'hFF, 8'h00);
        chk("hv slow", {7'h00, hv_on_o}, 8'h00);
        wr(CTL, 8'h00);
        slow_clk_i <= 1'b0;
        secure_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(pa[1], 8'hFF, 8'h00);
        secure_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(pa[1], 8'hFF, pd[1]);
        $display("test slow and secure done");
        rd(16'h7FF0, 8'hFF, 8'h00);
        rd(16'hFFF1, 8'hFF, 8'h00);
        $display("test unmapped done");
        prog(PROT, 8'h01);
        hv_op(8'h01, 16'h7820, 8'hAA, 8'hFF, 8'h01);
        chk("hv protected", {7'h00, hv_on_o}, 8'h00);
        rd(CTL, 8'hFF, 8'h00);
        wr(CTL, 8'h00);
        $display("test protect done");
        repeat (4) @(posedge clk_i);
        report_and_stop();
    end
endmodule : flash_program_erase_control_test
